// ===== inc/rcf_pkg.sv
package rcf_pkg;
  // bit positions of the reset cause status register
  localparam int unsigned BIT_BROWNOUT = 0;
  localparam int unsigned BIT_POWERON  = 1;
  localparam int unsigned BIT_PWRDN    = 2;
  localparam int unsigned BIT_WDOG     = 3;
  localparam int unsigned BIT_RSTINSTR = 4;
  localparam int unsigned BIT_CFGMIS   = 5;
  localparam int unsigned BIT_PRIO     = 7;
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_CFG_BASE = 4'h8;
  // bits 7..0 = prio, -, cm, ri, to, pd, por, bor
  localparam logic [7:0] STATUS_RESET  = 8'h3c;
  localparam logic [7:0] WRITE_MASK    = 8'hb3;
  localparam int unsigned CFG_WORDS    = 4;
  localparam int unsigned CFG_W        = 16;

  typedef struct packed {
    logic por;       // power applied
    logic brownout;  // supply dip
    logic mclr;      // external master clear
    logic wdog;      // watchdog expiry
    logic instr;     // reset instruction
    logic stack;     // stack event
    logic cfgmis;    // configuration mismatch
  } rcf_cause_s;

  typedef enum logic [1:0] {
    RCF_RUN, RCF_LOAD
  } rcf_state_e;
endpackage : rcf_pkg

// ===== design/rcf_top.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Behaviour
// R1 - The power-down flag goes to 1 at power-up and whenever the clear-watchdog instruction runs.
// R2 - The power-down flag goes to 0 whenever the sleep instruction runs; the code leaves it at 1 when clear-watchdog runs in the same cycle.
// R3 - The watchdog flag goes to 0 when the watchdog times out.
// R4 - A configuration mismatch reset acts like master clear, reset instruction, watchdog or stack resets.
// R5 - Every hard or power reset reloads the configuration words from program memory before running.
// R6 - Power-on, brown-out, reset-instruction and mismatch flags read 0 after their cause; software sets them to 1.
module rcf_top #(
  parameter int unsigned CFG_WORDS = rcf_pkg::CFG_WORDS,
  parameter int unsigned CFG_W     = rcf_pkg::CFG_W
) (
  input  wire logic                         core_clk,      // system clock
  input  wire logic                         reset,         // async, active high
  input  wire rcf_pkg::rcf_cause_s          cause,         // one-cycle reset cause pulses
  input  wire logic                         sleep_exec,    // sleep instruction pulse
  input  wire logic                         clear_watchdog_instruction_exec,   // clear-watchdog pulse
  input  wire logic [CFG_W-1:0]             flash_data,    // config word from program memory
  input  wire logic [3:0]                   addr,          // register address
  input  wire logic [7:0]                   wdata,         // write data
  input  wire logic                         wr,            // write strobe
  input  wire logic                         rd,            // read strobe
  output logic      [7:0]                   rdata,         // read data, cycle after rd
  output logic      [1:0]                   flash_addr,    // config word index
  output logic                              cpu_hold,      // core held while words load
  output logic      [CFG_W*CFG_WORDS-1:0]   config_words,  // loaded configuration
  output logic                              priority_level_enable // priority enable bit
);
  logic [7:0]                 status_r, status_nxt;
  logic [7:0]                 rdata_r, rdata_nxt;
  rcf_pkg::rcf_state_e        state_r, state_nxt;
  logic [1:0]                 idx_r, idx_nxt;
  logic [CFG_W*CFG_WORDS-1:0] cfg_r, cfg_nxt;
  logic                       hard_rst;
  logic                       hold_r, hold_nxt;

  // mismatch folds into the same hard-reset path as the other sources
  assign hard_rst = cause.por | cause.brownout | cause.mclr | cause.wdog |
                    cause.instr | cause.stack | cause.cfgmis; // R4

  always_comb begin
    status_nxt = status_r;
    if (wr && addr == rcf_pkg::ADDR_STATUS) begin
      status_nxt = (status_r & ~rcf_pkg::WRITE_MASK) | (wdata & rcf_pkg::WRITE_MASK); // R6
    end
    // hardware events come after the write so a coincident cause wins
    if (cause.mclr | cause.instr | cause.stack | cause.cfgmis | cause.wdog) begin
      status_nxt[rcf_pkg::BIT_PRIO] = 1'b0;
    end
    if (sleep_exec) begin
      status_nxt[rcf_pkg::BIT_PWRDN] = 1'b0; // R2
      status_nxt[rcf_pkg::BIT_WDOG]  = 1'b1;
    end
    if (clear_watchdog_instruction_exec) begin
      status_nxt[rcf_pkg::BIT_PWRDN] = 1'b1; // R1
      status_nxt[rcf_pkg::BIT_WDOG]  = 1'b1;
    end
    if (cause.wdog) begin
      status_nxt[rcf_pkg::BIT_WDOG] = 1'b0; // R3
    end
    if (cause.instr) begin
      status_nxt[rcf_pkg::BIT_RSTINSTR] = 1'b0; // R6
    end
    if (cause.cfgmis) begin
      status_nxt[rcf_pkg::BIT_CFGMIS] = 1'b0; // R6
    end
    if (cause.brownout) begin
      status_nxt[rcf_pkg::BIT_BROWNOUT] = 1'b0; // R6
    end
    if (cause.por) begin
      status_nxt = rcf_pkg::STATUS_RESET; // R1
      status_nxt[rcf_pkg::BIT_POWERON]  = 1'b0; // R6
      status_nxt[rcf_pkg::BIT_BROWNOUT] = 1'b0;
    end
    status_nxt[6] = 1'b0;
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (rd) begin
      if (addr == rcf_pkg::ADDR_STATUS) begin
        rdata_nxt = status_r;
      end else if (addr[3] == rcf_pkg::ADDR_CFG_BASE[3]) begin
        // low then high byte of each loaded word; unmapped reads as zero
        rdata_nxt = cfg_r[{addr[2:0], 3'h0} +: 8];
      end
    end
  end

  // walks the words out of program memory; any hard reset restarts the walk
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    cfg_nxt   = cfg_r;
    if (hard_rst) begin
      state_nxt = rcf_pkg::RCF_LOAD; // R5
      idx_nxt   = 2'h0;
    end else begin
      unique case (state_r)
        rcf_pkg::RCF_RUN: begin
        end
        rcf_pkg::RCF_LOAD: begin
          cfg_nxt[idx_r*CFG_W +: CFG_W] = flash_data; // R5
          idx_nxt = idx_r + 2'h1;
          if (idx_r == 2'(CFG_WORDS-1)) begin
            state_nxt = rcf_pkg::RCF_RUN;
            idx_nxt   = 2'h0;
          end
        end
        default: state_nxt = rcf_pkg::RCF_LOAD;
      endcase
    end
    hold_nxt = (state_nxt == rcf_pkg::RCF_LOAD);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_r <= rcf_pkg::STATUS_RESET;
      rdata_r  <= 8'h00;
      state_r  <= rcf_pkg::RCF_LOAD;
      hold_r   <= 1'b1;
      idx_r    <= 2'h0;
      cfg_r    <= '0;
    end else begin
      status_r <= status_nxt;
      rdata_r  <= rdata_nxt;
      state_r  <= state_nxt;
      hold_r   <= hold_nxt;
      idx_r    <= idx_nxt;
      cfg_r    <= cfg_nxt;
    end
  end

  // flash_addr is the index register itself, so data returns combinationally
  assign rdata                 = rdata_r;
  assign flash_addr            = idx_r;
  assign cpu_hold              = hold_r;
  assign config_words          = cfg_r;
  assign priority_level_enable = status_r[rcf_pkg::BIT_PRIO];

  sleep_clears_pd_a: assert property (@(posedge core_clk) disable iff (reset) // R2
    sleep_exec && !clear_watchdog_instruction_exec && !cause.por |=> !status_r[rcf_pkg::BIT_PWRDN])
    else $error("pd not cleared by sleep");
  clear_watchdog_instruction_sets_pd_a: assert property (@(posedge core_clk) disable iff (reset) // R1
    clear_watchdog_instruction_exec && !cause.por && !cause.wdog |=> status_r[rcf_pkg::BIT_PWRDN] && status_r[rcf_pkg::BIT_WDOG])
    else $error("pd not set by clear watchdog");
  por_sets_pd_a: assert property (@(posedge core_clk) disable iff (reset) // R1
    cause.por |=> status_r[rcf_pkg::BIT_PWRDN] && !status_r[rcf_pkg::BIT_POWERON])
    else $error("power-up flags wrong");
  wdog_clears_to_a: assert property (@(posedge core_clk) disable iff (reset) // R3
    cause.wdog && !cause.por |=> !status_r[rcf_pkg::BIT_WDOG])
    else $error("watchdog flag not cleared");
  mismatch_hold_a: assert property (@(posedge core_clk) disable iff (reset) // R4
    cause.cfgmis |=> cpu_hold && flash_addr == 2'h0)
    else $error("mismatch did not restart load");
  load_finishes_a: assert property (@(posedge core_clk) disable iff (reset) // R5
    hard_rst ##1 (!hard_rst)[*4] |=> !cpu_hold)
    else $error("config load length wrong");
  instr_clears_ri_a: assert property (@(posedge core_clk) disable iff (reset) // R6
    cause.instr && !cause.por |=> !status_r[rcf_pkg::BIT_RSTINSTR])
    else $error("reset instruction flag not cleared");
  sw_sets_ri_a: assert property (@(posedge core_clk) disable iff (reset) // R6
    wr && addr == rcf_pkg::ADDR_STATUS && wdata[rcf_pkg::BIT_RSTINSTR] && !hard_rst |=> status_r[rcf_pkg::BIT_RSTINSTR])
    else $error("software set of flag lost");
  read_data_a: assert property (@(posedge core_clk) disable iff (reset)
    rd && addr == rcf_pkg::ADDR_STATUS |=> rdata == $past(status_r))
    else $error("read data wrong");

  // bit 6 has no storage behind it
  unimpl_bit_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    !status_r[6])
    else $error("unused status bit set");

  // every hard cause but brown-out drops the priority enable; power-on does it through the reset value
  hard_clears_prio_a: assert property (@(posedge core_clk) disable iff (reset) // R4
    cause.mclr || cause.instr || cause.stack || cause.cfgmis || cause.wdog |=> !priority_level_enable)
    else $error("priority enable survived reset");

  // mismatch leaves its own mark so software can tell it apart
  cfgmis_clears_cm_a: assert property (@(posedge core_clk) disable iff (reset) // R6
    cause.cfgmis && !cause.por |=> !status_r[rcf_pkg::BIT_CFGMIS])
    else $error("mismatch flag not cleared");

  // brown-out marks itself
  brownout_clears_bor_a: assert property (@(posedge core_clk) disable iff (reset) // R6
    cause.brownout |=> !status_r[rcf_pkg::BIT_BROWNOUT])
    else $error("brown-out flag not cleared");

  // master clear and stack resets touch nothing but the priority enable
  mclr_keeps_flags_a: assert property (@(posedge core_clk) disable iff (reset) // R4
    hard_rst && !cause.por && !cause.brownout && !cause.wdog && !cause.instr && !cause.cfgmis &&
    !sleep_exec && !clear_watchdog_instruction_exec && !wr |=> status_r[5:0] == $past(status_r[5:0]))
    else $error("master clear changed flags");

  // software rearms the mismatch flag
  sw_writes_cm_a: assert property (@(posedge core_clk) disable iff (reset) // R6
    wr && addr == rcf_pkg::ADDR_STATUS && !hard_rst |=> status_r[rcf_pkg::BIT_CFGMIS] == $past(wdata[rcf_pkg::BIT_CFGMIS]))
    else $error("mismatch flag write lost");

  // software rearms the power-on flag
  sw_writes_por_a: assert property (@(posedge core_clk) disable iff (reset) // R6
    wr && addr == rcf_pkg::ADDR_STATUS && !cause.por |=> status_r[rcf_pkg::BIT_POWERON] == $past(wdata[rcf_pkg::BIT_POWERON]))
    else $error("power-on flag write lost");

  // the power-down flag is read-only to software
  pd_write_blocked_a: assert property (@(posedge core_clk) disable iff (reset) // R2
    wr && addr == rcf_pkg::ADDR_STATUS && !sleep_exec && !clear_watchdog_instruction_exec && !cause.por
    |=> status_r[rcf_pkg::BIT_PWRDN] == $past(status_r[rcf_pkg::BIT_PWRDN]))
    else $error("power-down flag written");

  // the watchdog flag is read-only to software
  to_write_blocked_a: assert property (@(posedge core_clk) disable iff (reset) // R3
    wr && addr == rcf_pkg::ADDR_STATUS && !sleep_exec && !clear_watchdog_instruction_exec && !cause.por && !cause.wdog
    |=> status_r[rcf_pkg::BIT_WDOG] == $past(status_r[rcf_pkg::BIT_WDOG]))
    else $error("watchdog flag written");

  // any hard cause restarts the walk from the first word
  hard_restart_a: assert property (@(posedge core_clk) disable iff (reset) // R5
    hard_rst |=> cpu_hold && flash_addr == 2'h0)
    else $error("load not restarted");

  // once loaded, the words stay put until the next hard cause
  run_cfg_stable_a: assert property (@(posedge core_clk) disable iff (reset) // R5
    !cpu_hold && !hard_rst |=> $stable(config_words))
    else $error("config changed while running");

  // the index rests at zero outside a load
  run_index_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    !cpu_hold |-> flash_addr == 2'h0)
    else $error("index not parked");

  // read data stands for one cycle only
  idle_rdata_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    !rd |=> rdata == 8'h00)
    else $error("read data left standing");

  // holes in the map read as zero
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (reset)
    rd && addr != rcf_pkg::ADDR_STATUS && !addr[3] |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // loaded words can be read back byte by byte
  cfg_read_a: assert property (@(posedge core_clk) disable iff (reset) // R5
    rd && addr[3] |=> rdata == 8'($past(config_words >> {addr[2:0], 3'h0})))
    else $error("config byte read wrong");

  // the walk moves one word per cycle
  hold_steps_a: assert property (@(posedge core_clk) disable iff (reset) // R5
    cpu_hold && !hard_rst && flash_addr != 2'(CFG_WORDS-1) |=> cpu_hold && flash_addr == $past(flash_addr) + 2'h1)
    else $error("load index skipped");

  // the core is let go right after the last word
  hold_ends_a: assert property (@(posedge core_clk) disable iff (reset) // R5
    cpu_hold && !hard_rst && flash_addr == 2'(CFG_WORDS-1) |=> !cpu_hold)
    else $error("hold not released");

  // sleep also marks the watchdog flag as not expired
  sleep_sets_to_a: assert property (@(posedge core_clk) disable iff (reset)
    sleep_exec && !cause.wdog |=> status_r[rcf_pkg::BIT_WDOG])
    else $error("sleep did not set watchdog flag");

  // power-up arms the four hardware flags together
  por_reload_a: assert property (@(posedge core_clk) disable iff (reset) // R1
    cause.por |=> status_r[5:2] == 4'hf)
    else $error("power-up flags not armed");

  // clear-watchdog is applied after sleep, so it wins a tie
  clear_watchdog_instruction_over_sleep_a: assert property (@(posedge core_clk) disable iff (reset) // R1
    sleep_exec && clear_watchdog_instruction_exec |=> status_r[rcf_pkg::BIT_PWRDN])
    else $error("clear watchdog lost to sleep");

  // without an event or a write the flags hold
  quiet_status_a: assert property (@(posedge core_clk) disable iff (reset)
    !wr && !hard_rst && !sleep_exec && !clear_watchdog_instruction_exec |=> $stable(status_r))
    else $error("status changed without cause");

  // one check per configuration word: each slot takes the flash word of its own index
  for (genvar w = 0; w < CFG_WORDS; w++) begin : g_word_chk
    load_word_a: assert property (@(posedge core_clk) disable iff (reset) // R5
      cpu_hold && !hard_rst && flash_addr == 2'(w) |=> config_words[w*CFG_W +: CFG_W] == $past(flash_data))
      else $error("config word not captured");
  end

  // counts held cycles; a stuck walk would hang the core for good
  logic [3:0] hold_len_r, hold_len_nxt;
  always_comb begin
    hold_len_nxt = 4'h0;
    if (cpu_hold && !hard_rst) begin
      hold_len_nxt = hold_len_r + 4'h1;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hold_len_r <= 4'h0;
    end else begin
      hold_len_r <= hold_len_nxt;
    end
  end
  hold_len_a: assert property (@(posedge core_clk) disable iff (reset) // R5
    hold_len_r <= 4'(CFG_WORDS))
    else $error("config load ran too long");

  cov_sleep_c:  cover property (@(posedge core_clk) disable iff (reset) sleep_exec ##1 clear_watchdog_instruction_exec);
  cov_wdog_c:   cover property (@(posedge core_clk) disable iff (reset) cause.wdog ##[1:8] !cpu_hold);
  cov_mis_c:    cover property (@(posedge core_clk) disable iff (reset) cause.cfgmis ##5 !cpu_hold);
  cov_swset_c:  cover property (@(posedge core_clk) disable iff (reset) cause.por ##[1:20] wr);
  cov_brown_c:  cover property (@(posedge core_clk) disable iff (reset) cause.brownout ##[1:20] rd);
endmodule : rcf_top

// ===== sim/reset_cause_flags_test.sv
`timescale 1ns/1ps
module reset_cause_flags_test;
  logic                core_clk = 0, reset = 1, sleep_exec = 0, clear_watchdog_instruction_exec = 0, wr = 0, rd = 0;
  rcf_pkg::rcf_cause_s cause = '0;
  logic [3:0]          addr = 4'h0;
  logic [7:0]          wdata = 8'h00, rdata;
  logic [15:0]         flash_data, mem [4];
  logic [1:0]          flash_addr;
  logic                cpu_hold, priority_level_enable;
  logic [63:0]         config_words, cfg_exp;
  int                  failures = 0, total_checks = 0, seed = 32'h91535c36, st = 8'h3c;
  // causes in struct order, msb first: por, brownout, mclr, wdog, instr, stack, cfgmis
  int                  clr_bit [7] = '{1, 0, -1, 3, 4, -1, 5};
  // power causes may also rewrite prio or neighbours, so prio is masked for both and bor is masked too for por
  int                  msk [7] = '{8'h3e, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  assign flash_data = mem[flash_addr];
  rcf_top i_dut (.core_clk, .reset, .cause, .sleep_exec, .clear_watchdog_instruction_exec, .flash_data, .addr, .wdata, .wr, .rd,
                 .rdata, .flash_addr, .cpu_hold, .config_words, .priority_level_enable);
  initial forever #12.5 core_clk = ~core_clk;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic fill;
    foreach (mem[k]) mem[k] = $random(seed);
    cfg_exp = {mem[3], mem[2], mem[1], mem[0]};
  endtask : fill
  task automatic wait_load;
    int n;
    n = 0;
    #1;
    while (cpu_hold !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 20) begin
      failures++;
      report_and_stop();
    end
    chk(n, 4);
    chk(config_words, cfg_exp);
  endtask : wait_load
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    if (a == 4'h0) st = (st & 8'h4c) | (d & 8'hb3);
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk(64'(rdata & m), 64'(e & m));
  endtask : rd_reg
  task automatic pulse(input logic [8:0] v);
    @(posedge core_clk);
    {cause, sleep_exec, clear_watchdog_instruction_exec} <= v;
    @(posedge core_clk);
    {cause, sleep_exec, clear_watchdog_instruction_exec} <= 9'h000;
  endtask : pulse
  initial begin
    fill();
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    wait_load();
    rd_reg(4'h0, st, 8'hff);
    rd_reg(4'h3, 8'h00, 8'hff);
    for (int k = 0; k < 8; k++) rd_reg(4'(8 + k), cfg_exp[8*k+:8], 8'hff);
    $display("test power-up load done");
    wr_reg(4'h0, 8'hff);
    #1;
    chk(64'(priority_level_enable), 64'(st[7]));
    for (int i = 0; i < 7; i++) begin
      wr_reg(4'h0, 8'hff);
      fill();
      pulse({7'h40 >> i, 2'b00});
      wait_load();
      if (clr_bit[i] >= 0) st[clr_bit[i]] = 1'b0;
      if (i > 1) st[7] = 1'b0;
      rd_reg(4'h0, st, msk[i]);
    end
    $display("test reset causes done");
    pulse(9'h002);
    st = (st & 8'hf3) | 8'h08;
    rd_reg(4'h0, st, 8'hff);
    pulse(9'h001);
    st = st | 8'h0c;
    rd_reg(4'h0, st, 8'hff);
    wr_reg(4'h0, 8'h00);
    rd_reg(4'h0, st, 8'hff);
    $display("test sleep and clear-watchdog done");
    report_and_stop();
  end
endmodule : reset_cause_flags_test
